// File: shared/ffci_pkg.sv
// Constants, types and reset state of the flash command sequencer host
package ffci_pkg;
   // Clock and bus timing
   localparam int CLK_NS        = 25;
   localparam int WR_PULSE_NS   = 50;
   localparam int WR_CYC        = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_NS     = 45;
   localparam int SYNC_STAGES   = 2;
   localparam int RD_CYC        = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
   localparam int ABORT_US      = 10;
   localparam int ABORT_CYC     = (ABORT_US * 1000) / CLK_NS;
   localparam longint ERASE_MAX_NS = 64'd4000000000;
   localparam int POLL_LIMIT_DEF = int'(ERASE_MAX_NS / (CLK_NS * (RD_CYC + 1)));
   localparam int POLL_W        = 26;
   localparam logic [3:0] WR_CNT_LOAD = 4'(WR_CYC - 1);
   localparam logic [3:0] RD_CNT_LOAD = 4'(RD_CYC - 1);
   localparam logic [POLL_W-1:0] ABORT_LOAD = POLL_W'(ABORT_CYC);

   // Command addresses (only the low eleven bits matter to the device)
   localparam logic [15:0] ADDR_UNLOCK1 = 16'h0555;
   localparam logic [15:0] ADDR_UNLOCK2 = 16'h02AA;
   localparam logic [15:0] ADDR_ANY     = 16'h0000;
   localparam int          SIG_SEL_BIT  = 1;

   // Command data codes
   localparam logic [7:0] CODE_UNLOCK1  = 8'hAA;
   localparam logic [7:0] CODE_UNLOCK2  = 8'h55;
   localparam logic [7:0] CODE_RESET    = 8'hF0;
   localparam logic [7:0] CODE_AUTOSEL  = 8'h90;
   localparam logic [7:0] CODE_PROGRAM  = 8'hA0;
   localparam logic [7:0] CODE_BYPASS   = 8'h20;
   localparam logic [7:0] CODE_ERASE1   = 8'h80;
   localparam logic [7:0] CODE_ERASE2   = 8'h10;
   localparam logic [7:0] CODE_BYP_EXIT = 8'h00;

   // Status byte fields
   localparam int POLLING_BIT = 7;
   localparam int TOGGLE_BIT  = 6;
   localparam int ERROR_BIT   = 5;

   typedef enum logic [2:0] {
      OP_READ = 3'h0, OP_RESET = 3'h1, OP_AUTOSEL = 3'h2, OP_PROGRAM = 3'h3,
      OP_BYP_ENTER = 3'h4, OP_BYP_PROG = 3'h5, OP_BYP_EXIT = 3'h6, OP_ERASE = 3'h7
   } ffci_op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_W_SETUP = 3'h1, ST_W_PULSE = 3'h3, ST_W_HOLD = 3'h2,
      ST_R_PULSE = 3'h6, ST_R_SAMPLE = 3'h7, ST_FINISH = 3'h5, ST_ABORT_WAIT = 3'h4
   } ffci_st_t;

   typedef struct packed {
      ffci_op_t    op;
      logic [15:0] addr;
      logic [7:0]  data;
   } ffci_cmd_t;

   typedef struct packed {
      logic [7:0] data;
      logic       error;
   } ffci_rsp_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  dq_out;
      logic        dq_oe;
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
   } ffci_pins_t;

   typedef struct packed {
      ffci_st_t          st;
      ffci_op_t          op;
      logic              fail;
      logic              errseen;
      logic              first;
      logic              prev_tog;
      logic [3:0]        cnt;
      logic [2:0]        step;
      logic [15:0]       addr;
      logic [7:0]        data;
      ffci_pins_t        pins;
      logic [7:0]        sync1;
      logic [7:0]        sync2;
      logic [POLL_W-1:0] polls;
      logic              rsp_valid;
      ffci_rsp_t         rsp;
   } ffci_state_t;

   localparam ffci_pins_t PINS_IDLE = '{addr: 16'h0000, dq_out: 8'h00, dq_oe: 1'b0,
                                        ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
   localparam ffci_state_t STATE_RESET = '{st: ST_IDLE, op: OP_READ, pins: PINS_IDLE,
                                           default: '0};
endpackage : ffci_pkg

// File: core/ffci_host.sv
// Host-side command sequencer driving a byte-wide flash over its async pins
// Summary of operation
// - Reset is a single F0 write, with no unlock pair
// - Auto select by AA, 55, 90 writes
// - Program: AA, 55, A0, then address/data
// - Bypass entry by AA, 55, 20 writes
// - Bypass program: A0 then address/data
// - Bypass exit: 90 then 00
// - Erase: six writes ending 10 at 555
// - Address at strobe fall, data at rise, OE high
module ffci_host #(
   parameter int unsigned POLL_LIMIT = ffci_pkg::POLL_LIMIT_DEF
) (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // Command request
   input  wire logic                cmd_valid,
   output      logic                cmd_ready,
   input  wire ffci_pkg::ffci_cmd_t cmd,
   // Command answer
   output      logic                rsp_valid,
   output      ffci_pkg::ffci_rsp_t rsp,
   // Flash pins
   output      logic [15:0]         address_inputs,
   output      logic [7:0]          data_lines_out,
   output      logic                data_lines_oe,
   input  wire logic [7:0]          data_lines_in,
   output      logic                chip_select_n,
   output      logic                write_strobe_n,
   output      logic                output_enable_n
);
   if (POLL_LIMIT < 2 || POLL_LIMIT >= (1 << ffci_pkg::POLL_W)) begin : g_bad_limit
      $error("POLL_LIMIT out of range");
   end

   ffci_pkg::ffci_state_t s;
   ffci_pkg::ffci_state_t next_s;

   localparam logic [ffci_pkg::POLL_W-1:0] POLL_W_LIMIT = ffci_pkg::POLL_W'(POLL_LIMIT);

   function automatic logic [2:0] wr_count(ffci_pkg::ffci_op_t op, logic fail);
      if (fail) begin
         return 3'h1;
      end
      case (op)
         ffci_pkg::OP_READ:      return 3'h0;
         ffci_pkg::OP_RESET:     return 3'h1;
         ffci_pkg::OP_BYP_PROG,
         ffci_pkg::OP_BYP_EXIT:  return 3'h2;
         ffci_pkg::OP_PROGRAM:   return 3'h4;
         ffci_pkg::OP_ERASE:     return 3'h6;
         default:                return 3'h3;
      endcase
   endfunction : wr_count

   // Address and data of write number step of an operation
   function automatic logic [23:0] wr_word(ffci_pkg::ffci_op_t op, logic fail,
                                           logic [2:0] step, logic [15:0] a,
                                           logic [7:0] d);
      logic [7:0] third;
      third = ffci_pkg::CODE_PROGRAM;
      if (fail || op == ffci_pkg::OP_RESET) begin
         return {ffci_pkg::ADDR_ANY, ffci_pkg::CODE_RESET};
      end
      if (op == ffci_pkg::OP_BYP_EXIT) begin
         return {ffci_pkg::ADDR_ANY, (step == 3'h0) ? ffci_pkg::CODE_AUTOSEL
                                                     : ffci_pkg::CODE_BYP_EXIT};
      end
      if (op == ffci_pkg::OP_BYP_PROG) begin
         return (step == 3'h0) ? {ffci_pkg::ADDR_ANY, ffci_pkg::CODE_PROGRAM} : {a, d};
      end
      case (op)
         ffci_pkg::OP_AUTOSEL:   third = ffci_pkg::CODE_AUTOSEL;
         ffci_pkg::OP_BYP_ENTER: third = ffci_pkg::CODE_BYPASS;
         ffci_pkg::OP_ERASE:     third = ffci_pkg::CODE_ERASE1;
         default:                third = ffci_pkg::CODE_PROGRAM;
      endcase
      case (step)
         3'h0, 3'h3: begin
            if (step == 3'h3 && op == ffci_pkg::OP_PROGRAM) begin
               return {a, d};
            end
            return {ffci_pkg::ADDR_UNLOCK1, ffci_pkg::CODE_UNLOCK1};
         end
         3'h1, 3'h4: return {ffci_pkg::ADDR_UNLOCK2, ffci_pkg::CODE_UNLOCK2};
         3'h2:       return {ffci_pkg::ADDR_UNLOCK1, third};
         default:    return {ffci_pkg::ADDR_UNLOCK1, ffci_pkg::CODE_ERASE2};
      endcase
   endfunction : wr_word

   function automatic logic is_poll(ffci_pkg::ffci_op_t op);
      return op == ffci_pkg::OP_PROGRAM || op == ffci_pkg::OP_BYP_PROG ||
             op == ffci_pkg::OP_ERASE;
   endfunction : is_poll

   always_comb begin
      logic [23:0] w;
      logic [15:0] raddr;
      w = '0;
      raddr = '0;
      next_s = s;
      next_s.sync1 = data_lines_in;
      next_s.sync2 = s.sync1;
      next_s.rsp_valid = 1'b0;
      case (s.st)
         ffci_pkg::ST_IDLE: begin
            if (cmd_valid) begin
               next_s.op = cmd.op;
               next_s.addr = cmd.addr;
               next_s.data = cmd.data;
               next_s.step = 3'h0;
               next_s.fail = 1'b0;
               if (cmd.op == ffci_pkg::OP_READ) begin
                  next_s.st = ffci_pkg::ST_R_PULSE;
                  next_s.cnt = ffci_pkg::RD_CNT_LOAD;
                  next_s.pins = '{addr: cmd.addr, dq_out: 8'h00, dq_oe: 1'b0,
                                  ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0};
               end else begin
                  w = wr_word(cmd.op, 1'b0, 3'h0, cmd.addr, cmd.data);
                  next_s.st = ffci_pkg::ST_W_SETUP;
                  next_s.pins = '{addr: w[23:8], dq_out: w[7:0], dq_oe: 1'b1,
                                  ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b1};
               end
            end
         end
         ffci_pkg::ST_W_SETUP: begin
            next_s.st = ffci_pkg::ST_W_PULSE;
            next_s.pins.we_n = 1'b0;
            next_s.cnt = ffci_pkg::WR_CNT_LOAD;
         end
         ffci_pkg::ST_W_PULSE: begin
            if (s.cnt == 4'h0) begin
               // Data still driven one cycle past the rising strobe
               next_s.st = ffci_pkg::ST_W_HOLD;
               next_s.pins.we_n = 1'b1;
            end else begin
               next_s.cnt = 4'(s.cnt - 4'h1);
            end
         end
         ffci_pkg::ST_W_HOLD: begin
            next_s.step = 3'(s.step + 3'h1);
            next_s.pins = ffci_pkg::PINS_IDLE;
            if (3'(s.step + 3'h1) < wr_count(s.op, s.fail)) begin
               w = wr_word(s.op, s.fail, 3'(s.step + 3'h1), s.addr, s.data);
               next_s.st = ffci_pkg::ST_W_SETUP;
               next_s.pins = '{addr: w[23:8], dq_out: w[7:0], dq_oe: 1'b1,
                               ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b1};
            end else if (s.fail) begin
               // Erase abort leaves the array unreadable for a while
               next_s.st = (s.op == ffci_pkg::OP_ERASE) ? ffci_pkg::ST_ABORT_WAIT
                                                        : ffci_pkg::ST_FINISH;
               next_s.polls = ffci_pkg::ABORT_LOAD;
            end else if (s.op == ffci_pkg::OP_AUTOSEL || is_poll(s.op)) begin
               raddr = s.addr;
               if (s.op == ffci_pkg::OP_AUTOSEL) begin
                  raddr[ffci_pkg::SIG_SEL_BIT] = 1'b0;
               end
               next_s.st = ffci_pkg::ST_R_PULSE;
               next_s.cnt = ffci_pkg::RD_CNT_LOAD;
               next_s.first = 1'b1;
               next_s.errseen = 1'b0;
               next_s.polls = '0;
               next_s.pins = '{addr: raddr, dq_out: 8'h00, dq_oe: 1'b0,
                               ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0};
            end else begin
               next_s.st = ffci_pkg::ST_FINISH;
            end
         end
         ffci_pkg::ST_R_PULSE: begin
            if (s.cnt == 4'h0) begin
               next_s.data = s.sync2;
               next_s.st = ffci_pkg::ST_R_SAMPLE;
               next_s.pins = ffci_pkg::PINS_IDLE;
            end else begin
               next_s.cnt = 4'(s.cnt - 4'h1);
            end
         end
         ffci_pkg::ST_R_SAMPLE: begin
            next_s.prev_tog = s.data[ffci_pkg::TOGGLE_BIT];
            next_s.first = 1'b0;
            next_s.cnt = ffci_pkg::RD_CNT_LOAD;
            next_s.pins = '{addr: s.pins.addr, dq_out: 8'h00, dq_oe: 1'b0,
                            ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0};
            next_s.st = ffci_pkg::ST_R_PULSE;
            next_s.pins.addr = s.addr;
            if (!is_poll(s.op)) begin
               next_s.st = ffci_pkg::ST_FINISH;
               next_s.pins = ffci_pkg::PINS_IDLE;
            end else if (s.first) begin
               next_s.polls = s.polls;
            end else if (s.data[ffci_pkg::TOGGLE_BIT] == s.prev_tog) begin
               next_s.st = ffci_pkg::ST_FINISH;
               next_s.pins = ffci_pkg::PINS_IDLE;
            end else if ((s.data[ffci_pkg::ERROR_BIT] && s.errseen) ||
                         s.polls == POLL_W_LIMIT) begin
               // Toggling on after the error bit, or poll budget spent: clear with a reset write
               w = wr_word(s.op, 1'b1, 3'h0, s.addr, s.data);
               next_s.fail = 1'b1;
               next_s.step = 3'h0;
               next_s.st = ffci_pkg::ST_W_SETUP;
               next_s.pins = '{addr: w[23:8], dq_out: w[7:0], dq_oe: 1'b1,
                               ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b1};
            end else begin
               next_s.errseen = s.data[ffci_pkg::ERROR_BIT];
               next_s.polls = ffci_pkg::POLL_W'(s.polls + 1'b1);
            end
         end
         ffci_pkg::ST_ABORT_WAIT: begin
            if (s.polls == '0) begin
               next_s.st = ffci_pkg::ST_FINISH;
            end else begin
               next_s.polls = ffci_pkg::POLL_W'(s.polls - 1'b1);
            end
         end
         ffci_pkg::ST_FINISH: begin
            next_s.rsp_valid = 1'b1;
            next_s.rsp = '{data: s.data, error: s.fail};
            next_s.st = ffci_pkg::ST_IDLE;
         end
         default: begin
            next_s = ffci_pkg::STATE_RESET;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= ffci_pkg::STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign cmd_ready       = (s.st == ffci_pkg::ST_IDLE);
   assign rsp_valid       = s.rsp_valid;
   assign rsp             = s.rsp;
   assign address_inputs  = s.pins.addr;
   assign data_lines_out  = s.pins.dq_out;
   assign data_lines_oe   = s.pins.dq_oe;
   assign chip_select_n   = s.pins.ce_n;
   assign write_strobe_n  = s.pins.we_n;
   assign output_enable_n = s.pins.oe_n;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_take(ffci_pkg::ffci_op_t o);
      cmd_valid && cmd_ready && cmd.op == o;
   endsequence
   sequence s_strobe_low;
      !write_strobe_n && !chip_select_n;
   endsequence

   AST_NO_READ_IN_WRITE: assert property (
      !write_strobe_n |-> output_enable_n && data_lines_oe)
      else $error("write strobe low without output enable high");
   AST_ADDR_STABLE: assert property (
      s_strobe_low ##1 s_strobe_low |-> $stable(address_inputs) && $stable(data_lines_out))
      else $error("address or data moved during write strobe");
   AST_PULSE_WIDTH: assert property (
      $fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 (write_strobe_n && data_lines_oe))
      else $error("write strobe width or data hold wrong");
   AST_READ_WIDTH: assert property (
      $fell(output_enable_n) |-> !output_enable_n [*4] ##1 output_enable_n)
      else $error("read strobe width wrong");
   AST_PROG_FIRST: assert property (
      s_take(ffci_pkg::OP_PROGRAM) |-> ##1 address_inputs[10:0] == 11'h555 &&
      data_lines_out == 8'hAA ##1 s_strobe_low)
      else $error("program does not open with unlock write");
   AST_BYP_PROG_FIRST: assert property (
      s_take(ffci_pkg::OP_BYP_PROG) |->
      ##2 !write_strobe_n && !chip_select_n && data_lines_out == 8'hA0)
      else $error("bypass program does not open with A0");
   AST_RESET_ONE_WRITE: assert property (
      s_take(ffci_pkg::OP_RESET) |->
      ##2 !write_strobe_n && !chip_select_n && data_lines_out == 8'hF0
      ##[1:8] rsp_valid)
      else $error("reset command not a single F0 write");
   AST_FAIL_CLEARS: assert property (
      $rose(s.fail) |-> ##1 !write_strobe_n && !chip_select_n && data_lines_out == 8'hF0)
      else $error("failure not cleared by reset write");
   AST_AUTOSEL_SIG: assert property (
      s.op == ffci_pkg::OP_AUTOSEL && !output_enable_n |-> !address_inputs[1])
      else $error("signature read with second address bit high");
   AST_ERASE_LAST: assert property (
      s.op == ffci_pkg::OP_ERASE && !s.fail && s.step == 3'h5 &&
      !write_strobe_n && !chip_select_n |->
      address_inputs == 16'h0555 && data_lines_out == 8'h10)
      else $error("erase sixth write wrong");
   AST_ABORT_WAIT: assert property (
      $rose(s.st == ffci_pkg::ST_ABORT_WAIT) |-> !rsp_valid [*8])
      else $error("answer given during erase abort");
endmodule : ffci_host

// File: dv/ffci_flash_model.sv
// Behavioural flash device answering the host's pin-level bus cycles
module ffci_flash_model #(
   parameter logic [7:0] MAKER_CODE  = 8'h5C, // Arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'hC5, // Arbitrary value
   parameter int         PROG_NS     = 500
) (
   // Flash pins
   input  wire logic [15:0] address_inputs,
   input  wire logic [7:0]  data_lines_out,
   input  wire logic        data_lines_oe,
   output      logic [7:0]  data_lines_in,
   input  wire logic        chip_select_n,
   input  wire logic        write_strobe_n,
   input  wire logic        output_enable_n
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int M_READ = 0;
   localparam int M_SIG  = 1;
   localparam int M_BYP  = 2;
   logic [7:0]  mem [int];
   int          erase_ns = 1000;
   logic [15:0] wr_addr  = 16'h0000;
   logic        armed    = 1'b0;
   logic [7:0]  rd_q     = 8'h00;
   logic [7:0]  pd       = 8'h00;
   int          step     = 0;
   int          mode     = M_READ;
   logic        err      = 1'b0;
   logic        erasing  = 1'b0;
   logic        tog      = 1'b0;
   time         done_at  = 0;

   function automatic logic busy();
      return ($time < done_at) || err;
   endfunction : busy

   task automatic start_prog(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] cur;
      cur = mem.exists(a) ? mem[a] : 8'hFF;
      pd = d;
      erasing = 1'b0;
      // A refused program leaves the cell as it was
      if ((d & ~cur) != 8'h00) err = 1'b1;
      else begin
         mem[a] = cur & d;
         done_at = $time + PROG_NS;
      end
   endtask : start_prog

   task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
      logic hit;
      hit = 1'b1;
      if (busy()) begin
         // Only a reset is heard while busy, and not during a program; anything else is dropped
         if (d == 8'hF0 && err) begin
            err = 1'b0;
            done_at = 0;
         end else if (d == 8'hF0 && erasing) done_at = $time + 10000;
      end else if (mode == M_BYP) begin
         if (step == 1) start_prog(a, d);
         else if (step == 2 && d == 8'h00) mode = M_READ;
         step = (step == 0 && d == 8'hA0) ? 1 : (step == 0 && d == 8'h90) ? 2 : 0;
      end else begin
         hit = 1'b0;
         case (step)
            0, 3: hit = a[10:0] == 11'h555 && d == 8'hAA;
            1, 4: hit = a[10:0] == 11'h2AA && d == 8'h55;
            2: begin
               hit = a[10:0] == 11'h555 && d inside {8'h90, 8'h20, 8'hA0, 8'h80};
               if (hit && d == 8'h90) mode = M_SIG;
               if (hit && d == 8'h20) mode = M_BYP;
            end
            5: begin
               hit = a[10:0] == 11'h555 && d == 8'h10;
               if (hit) begin
                  erasing = 1'b1;
                  mem.delete();
                  done_at = $time + erase_ns;
               end
            end
            default: start_prog(a, d);
         endcase
         if (!hit) mode = M_READ;
         if (!hit || step == 5 || step == 6) step = 0;
         else if (step == 2) step = (d == 8'hA0) ? 6 : (d == 8'h80) ? 3 : 0;
         else step = step + 1;
      end
   endtask : bus_write

   always @(negedge write_strobe_n or negedge chip_select_n)
      if (!write_strobe_n && !chip_select_n) begin
         wr_addr = address_inputs;
         armed = 1'b1;
      end

   always @(posedge write_strobe_n or posedge chip_select_n)
      if (armed) begin
         armed = 1'b0;
         if (output_enable_n) bus_write(wr_addr, data_lines_oe ? data_lines_out : ~rd_q);
      end

   // Short settle so the address launched with the strobe is seen
   always @(negedge output_enable_n or negedge chip_select_n) begin
      #1;
      if (!output_enable_n && !chip_select_n) begin
         if (busy()) begin
            tog = ~tog;
            rd_q = {!erasing && !pd[7], tog, err, 5'h00};
         end else if (mode == M_SIG)
            rd_q = address_inputs[1] ? 8'h00 : address_inputs[0] ? DEVICE_CODE : MAKER_CODE;
         else rd_q = mem.exists(address_inputs) ? mem[address_inputs] : 8'hFF;
      end
   end

   // No pull resistor: a released bus shows the inverse of the last byte
   assign data_lines_in = (!chip_select_n && !output_enable_n) ? rd_q : ~rd_q;
endmodule : ffci_flash_model

// File: dv/ffci_host_tb_top.sv
// Self-checking bench for the flash command sequencer host
module ffci_host_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      ffci_pkg::ffci_cmd_t c;
      logic [7:0]          exp;
      logic [7:0]          mask;
      logic                err;
   } ffci_row_t;
   localparam logic [7:0] MAKER  = 8'h5C; // Arbitrary value
   localparam logic [7:0] DEVICE = 8'hC5; // Arbitrary value
   localparam int         NROW   = 18;
   localparam ffci_row_t ROWS [NROW] = '{
      '{'{ffci_pkg::OP_ERASE,     16'h0000, 8'h00}, 8'hFF, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_PROGRAM,   16'hF234, 8'h5A}, 8'h5A, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_READ,      16'hF234, 8'h00}, 8'h5A, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_PROGRAM,   16'hF234, 8'hA5}, 8'h00, 8'h00, 1'b1},
      '{'{ffci_pkg::OP_READ,      16'hF234, 8'h00}, 8'h5A, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_AUTOSEL,   16'hFFFC, 8'h00}, MAKER, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_AUTOSEL,   16'h0001, 8'h00}, DEVICE, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_RESET,     16'h0000, 8'h00}, 8'h00, 8'h00, 1'b0},
      '{'{ffci_pkg::OP_READ,      16'h0001, 8'h00}, 8'hFF, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_BYP_PROG,  16'h0200, 8'h00}, 8'hFF, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_READ,      16'h0200, 8'h00}, 8'hFF, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_BYP_ENTER, 16'h0000, 8'h00}, 8'h00, 8'h00, 1'b0},
      '{'{ffci_pkg::OP_BYP_PROG,  16'h0100, 8'h3C}, 8'h3C, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_BYP_PROG,  16'h0100, 8'hC3}, 8'h00, 8'h00, 1'b1},
      '{'{ffci_pkg::OP_BYP_PROG,  16'h0101, 8'h11}, 8'h11, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_READ,      16'h0100, 8'h00}, 8'h3C, 8'hFF, 1'b0},
      '{'{ffci_pkg::OP_BYP_EXIT,  16'h0000, 8'h00}, 8'h00, 8'h00, 1'b0},
      '{'{ffci_pkg::OP_READ,      16'h0101, 8'h00}, 8'h11, 8'hFF, 1'b0}
   };
   logic                core_clk  = 1'b0;
   logic                rst_n     = 1'b0;
   logic                cmd_valid = 1'b0;
   ffci_pkg::ffci_cmd_t cmd       = '0;
   logic                cmd_ready;
   logic                rsp_valid;
   ffci_pkg::ffci_rsp_t rsp;
   ffci_pkg::ffci_rsp_t r;
   logic [15:0]         address_inputs;
   logic [7:0]          data_lines_out;
   logic                data_lines_oe;
   logic [7:0]          data_lines_in;
   logic                chip_select_n;
   logic                write_strobe_n;
   logic                output_enable_n;
   int                  error_cnt = 0;
   int                  compares  = 0;
   int                  t0;

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   ffci_host #(.POLL_LIMIT(20)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .address_inputs(address_inputs),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
      .data_lines_in(data_lines_in), .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n));

   ffci_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_flash (
      .address_inputs(address_inputs), .data_lines_out(data_lines_out),
      .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in),
      .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
      .output_enable_n(output_enable_n));

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check

   // Hands one command over and waits for its answer under a bound
   task automatic run(input ffci_pkg::ffci_cmd_t c);
      int n;
      @(posedge core_clk);
      cmd <= c;
      cmd_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 50);
      cmd_valid <= 1'b0;
      if (cmd_ready !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t command not taken", $time);
         report_and_stop();
      end
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 20000);
      if (rsp_valid !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t no answer", $time);
         report_and_stop();
      end else r = rsp;
   endtask : run

   initial begin
      // State is unknown until the first edge under reset
      @(posedge core_clk);
      #1;
      check(chip_select_n === 1'b1 && write_strobe_n === 1'b1 && cmd_ready === 1'b1, "idle");
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < NROW; i++) begin
         run(ROWS[i].c);
         check((r.data & ROWS[i].mask) === (ROWS[i].exp & ROWS[i].mask), "data");
         check(r.error === ROWS[i].err, "error flag");
         $display("Row %0d done", i);
      end
      // Reset in mid-command leaves the pins idle at once
      run('{ffci_pkg::OP_READ, 16'h0000, 8'h00});
      cmd <= '{ffci_pkg::OP_PROGRAM, 16'h0300, 8'h00};
      cmd_valid <= 1'b1;
      repeat (9) @(posedge core_clk);
      cmd_valid <= 1'b0;
      rst_n <= 1'b0;
      #1 check(write_strobe_n === 1'b1 && output_enable_n === 1'b1 && rsp_valid === 1'b0, "rst");
      @(posedge core_clk);
      rst_n <= 1'b1;
      run('{ffci_pkg::OP_RESET, 16'h0000, 8'h00});
      run('{ffci_pkg::OP_READ, 16'h0300, 8'h00});
      check(r.data === 8'hFF, "no program after reset");
      $display("Reset test done");
      // Erase outlasting the poll budget is aborted by a reset
      u_flash.erase_ns = 200000;
      t0 = $time;
      run('{ffci_pkg::OP_ERASE, 16'h0000, 8'h00});
      check(r.error === 1'b1, "erase abort");
      check(($time - t0) > 400 * 25, "abort wait");
      u_flash.erase_ns = 1000;
      run('{ffci_pkg::OP_ERASE, 16'h0000, 8'h00});
      check(r.error === 1'b0 && r.data === 8'hFF, "erase after abort");
      $display("Abort test done");
      report_and_stop();
   end
endmodule : ffci_host_tb_top
